// >>> logic/ep0_buf_pkg.sv
// Constants, register map and field layout for the endpoint-zero
// control data-stage buffering block.
// Assumes a single 125 MHz clock and a 32-bit AHB-Lite register bus.
package ep0_buf_pkg;

   // Shared packet FIFO: 3 Kbytes in 64-byte blocks 0 .. 2F
   localparam int          FIFO_BYTES     = 3072;
   localparam int          FIFO_IDX_W     = 12;
   localparam int          BLOCK_SHIFT    = 6;
   localparam logic [5:0]  LAST_BLOCK     = 6'h2F;
   localparam logic [8:0]  CONT_MAX_BYTES = 9'h100;

   // Byte addresses on the register bus
   localparam logic [7:0]  OFF_CFG        = 8'h28;
   localparam logic [7:0]  OFF_MPKT       = 8'h40;
   localparam logic [7:0]  OFF_TX_LEN     = 8'h44;
   localparam logic [7:0]  OFF_FIFO_CTRL  = 8'h48;
   localparam logic [7:0]  OFF_TX_DATA    = 8'h4C;
   localparam logic [7:0]  OFF_RX_DATA    = 8'h50;
   localparam logic [7:0]  OFF_STATUS     = 8'h54;

   // Transfer configuration register layout
   localparam logic [15:0] CFG_RESET      = 16'h0000;
   localparam logic [15:0] CFG_WMASK      = 16'hBFBF;
   localparam int          CFG_RD_CONT    = 15;
   localparam int          CFG_RD_BLK_LSB = 8;
   localparam int          CFG_WR_CONT    = 7;
   localparam int          CFG_WR_BLK_LSB = 0;

   localparam logic [6:0]  MPKT_RESET     = 7'h08;
   localparam logic [8:0]  TX_LEN_RESET   = 9'h000;

   // FIFO control bits
   localparam int          CTRL_VALID     = 0;
   localparam int          CTRL_RX_FULL   = 1;
   localparam int          CTRL_RX_REL    = 2;
   // Status bits, write one to clear
   localparam int          STAT_TX_DONE   = 0;
   localparam int          STAT_RX_DONE   = 1;
   localparam int          STAT_RX_OVER   = 2;
   localparam int          COUNT_LSB      = 16;

   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

   typedef enum logic [3:0] {
      TX_IDLE   = 4'h1,
      TX_LOAD   = 4'h2,
      TX_SEND   = 4'h4,
      TX_FINISH = 4'h8
   } tx_state_t;

endpackage

// >>> logic/ep0_fifo_ram.sv
// Shared packet FIFO storage, one flip-flop byte per entry.
// Two write ports and two asynchronous read ports; indices beyond the
// FIFO write nothing and read zero.
`timescale 1ns/1ps
`default_nettype none
module ep0_fifo_ram
   import ep0_buf_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  we_a,
   input  wire logic [FIFO_IDX_W-1:0] idx_a,
   input  wire logic [7:0]            wd_a,
   input  wire logic                  we_b,
   input  wire logic [FIFO_IDX_W-1:0] idx_b,
   input  wire logic [7:0]            wd_b,
   input  wire logic [FIFO_IDX_W-1:0] idx_r0,
   output logic      [7:0]            rd_r0,
   input  wire logic [FIFO_IDX_W-1:0] idx_r1,
   output logic      [7:0]            rd_r1
);
   localparam logic [FIFO_IDX_W-1:0] DEPTH = FIFO_IDX_W'(FIFO_BYTES);

   logic [7:0] mem [FIFO_BYTES];

   genvar i;
   generate
      for (i = 0; i < FIFO_BYTES; i++) begin : g_byte
         // Port b wins a collision; firmware must keep regions apart
         always_ff @(posedge clk) begin
            if (we_b && idx_b == FIFO_IDX_W'(i)) begin
               mem[i] <= wd_b;
            end else if (we_a && idx_a == FIFO_IDX_W'(i)) begin
               mem[i] <= wd_a;
            end
         end
      end
   endgenerate

   assign rd_r0 = (idx_r0 < DEPTH) ? mem[idx_r0] : 8'h00;
   assign rd_r1 = (idx_r1 < DEPTH) ? mem[idx_r1] : 8'h00;

endmodule // ep0_fifo_ram
`default_nettype wire

// >>> logic/ep0_ctrl_buffer.sv
// Endpoint-zero control data-stage buffering with AHB-Lite registers.
// Assumes a byte-stream packet link (serial engine) on the USB side.
// Function
// - Bit 15 picks single or continuous transmit
// - Single transmit ends after one packet
// - Continuous transmit ends at length or short
// - Single fill ends at max packet or valid
// - Continuous fill ends at length or valid
// - Bits 13..8 give control-read start block
// - Single transmit uses only its start block
// - Continuous transmit uses contiguous length-sized space
// - Three-kilobyte FIFO, blocks zero to 2F
// - Bit 7 picks unit or continuous receive
// - Unit receive ends after one packet
// - Continuous receive ends at 256 or short
// - Bits 5..0 give control-write start block
// - Unit receive uses only its start block
// - Continuous receive uses 256 contiguous bytes
// - Register clears on reset; reserved bits zero
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ep0_ctrl_buffer
   import ep0_buf_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic        tx_start,
   input  wire logic        tx_ready,
   output logic             tx_valid,
   output logic      [7:0]  tx_data,
   output logic             tx_last,
   output logic             tx_zero_length,
   output logic             tx_nak,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_end,
   output logic             rx_ready
);
   logic [15:0]     cfg;
   logic [6:0]      mpkt;
   logic [8:0]      tx_len;
   logic            wr_pend;
   logic [7:0]      wr_addr;
   logic            addr_take;
   logic            wr_phase;
   logic [31:0]     read_value;
   logic            read_cont;
   logic            write_cont;
   logic [5:0]      rd_blk;
   logic [5:0]      wr_blk;
   tx_state_t       tx_state;
   logic            buf_valid;
   logic [8:0]      tx_fill;
   logic [8:0]      tx_sent;
   logic [6:0]      pkt_len;
   logic [6:0]      pkt_cnt;
   logic [8:0]      fill_limit;
   logic [8:0]      remaining;
   logic [6:0]      next_pkt_len;
   logic            fill_take;
   logic            fw_valid;
   logic            tx_complete;
   logic            tx_done;
   logic            rx_full;
   logic [8:0]      rx_total;
   logic [6:0]      rx_pkt;
   logic [8:0]      rx_rd;
   logic            rx_pkt_over;
   logic [8:0]      rx_cap;
   logic            rx_take;
   logic            rx_store;
   logic            rx_finish;
   logic            rx_release;
   logic            rx_read;
   logic            rx_done;
   logic            rx_over;
   logic            stat_write;
   logic [7:0]      ram_tx_byte;
   logic [7:0]      ram_rx_byte;

   // Byte offset inside the FIFO: start block times 64 plus a linear offset
   function automatic logic [FIFO_IDX_W-1:0] buf_index(input logic [5:0] blk,
                                                      input logic [8:0] off);
      buf_index = (FIFO_IDX_W'(blk) << BLOCK_SHIFT) + FIFO_IDX_W'(off);
   endfunction

   // Register bus: zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addr_take = hsel && hready && htrans == HTRANS_NONSEQ;
   assign wr_phase  = wr_pend;

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= addr_take && hwrite;
         if (addr_take) begin
            wr_addr <= haddr[7:0];
         end
      end
   end

   assign read_cont  = cfg[CFG_RD_CONT];
   assign write_cont = cfg[CFG_WR_CONT];
   assign rd_blk     = cfg[CFG_RD_BLK_LSB +: 6];
   assign wr_blk     = cfg[CFG_WR_BLK_LSB +: 6];

   always_ff @(posedge clk) begin
      if (reset) begin
         cfg <= CFG_RESET;
      end else if (wr_phase && wr_addr == OFF_CFG) begin
         cfg <= hwdata[15:0] & CFG_WMASK;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mpkt <= MPKT_RESET;
      end else if (wr_phase && wr_addr == OFF_MPKT) begin
         mpkt <= hwdata[6:0];
      end
   end

   // Length above 256 would overrun the buffer, so it saturates
   always_ff @(posedge clk) begin
      if (reset) begin
         tx_len <= TX_LEN_RESET;
      end else if (wr_phase && wr_addr == OFF_TX_LEN) begin
         tx_len <= (hwdata[15:0] > 16'(CONT_MAX_BYTES)) ? CONT_MAX_BYTES : hwdata[8:0];
      end
   end

   always_comb begin
      read_value = 32'h0000_0000;
      case (haddr[7:0])
         OFF_CFG:       read_value = {16'h0000, cfg};
         OFF_MPKT:      read_value = {25'h0000000, mpkt};
         OFF_TX_LEN:    read_value = {23'h000000, tx_len};
         OFF_FIFO_CTRL: read_value = {7'h00, tx_fill, 14'h0000, rx_full, buf_valid};
         OFF_RX_DATA:   read_value = {24'h000000, ram_rx_byte};
         OFF_STATUS:    read_value = {7'h00, rx_total, 13'h0000, rx_over, rx_done, tx_done};
         default:       read_value = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_take && !hwrite) begin
         hrdata <= read_value;
      end
   end

   // Transmit buffer filling by firmware
   assign fill_limit = read_cont ? tx_len : {2'h0, mpkt};
   assign fill_take  = wr_phase && wr_addr == OFF_TX_DATA && !buf_valid
                       && tx_state == TX_IDLE && tx_fill < fill_limit;
   assign fw_valid   = wr_phase && wr_addr == OFF_FIFO_CTRL && hwdata[CTRL_VALID];
   assign remaining  = tx_fill - tx_sent;
   assign next_pkt_len = (remaining > {2'h0, mpkt}) ? mpkt : remaining[6:0];
   assign tx_complete = tx_state == TX_FINISH
                        && (!read_cont || 9'(tx_sent + {2'h0, pkt_len}) == tx_fill);

   always_ff @(posedge clk) begin
      if (reset) begin
         buf_valid <= 1'b0;
      end else if (fw_valid || (fill_take && 9'(tx_fill + 9'h001) == fill_limit)) begin
         buf_valid <= 1'b1;
      end else if (tx_complete) begin
         buf_valid <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tx_fill <= 9'h000;
         tx_sent <= 9'h000;
      end else if (tx_complete) begin
         tx_fill <= 9'h000;
         tx_sent <= 9'h000;
      end else begin
         if (fill_take) begin
            tx_fill <= 9'(tx_fill + 9'h001);
         end
         if (tx_state == TX_FINISH) begin
            tx_sent <= 9'(tx_sent + {2'h0, pkt_len});
         end
      end
   end

   // Transmit packet sequencer
   always_ff @(posedge clk) begin
      if (reset) begin
         tx_state       <= TX_IDLE;
         pkt_len        <= 7'h00;
         pkt_cnt        <= 7'h00;
         tx_data        <= 8'h00;
         tx_last        <= 1'b0;
         tx_zero_length <= 1'b0;
      end else begin
         tx_zero_length <= 1'b0;
         case (tx_state)
            TX_IDLE: begin
               if (tx_start && buf_valid) begin
                  pkt_len <= next_pkt_len;
                  pkt_cnt <= 7'h00;
                  if (next_pkt_len == 7'h00) begin
                     tx_zero_length <= 1'b1;
                     tx_state       <= TX_FINISH;
                  end else begin
                     tx_state <= TX_LOAD;
                  end
               end
            end
            TX_LOAD: begin
               tx_data  <= ram_tx_byte;
               tx_last  <= 7'(pkt_cnt + 7'h01) == pkt_len;
               tx_state <= TX_SEND;
            end
            TX_SEND: begin
               if (tx_ready) begin
                  pkt_cnt  <= 7'(pkt_cnt + 7'h01);
                  tx_state <= tx_last ? TX_FINISH : TX_LOAD;
               end
            end
            TX_FINISH: begin
               tx_last  <= 1'b0;
               tx_state <= TX_IDLE;
            end
            default: begin
               tx_state <= TX_IDLE;
            end
         endcase
      end
   end

   assign tx_valid = tx_state == TX_SEND;
   assign tx_nak   = tx_start && tx_state == TX_IDLE && !buf_valid;

   // Receive side
   assign rx_cap     = write_cont ? CONT_MAX_BYTES : {2'h0, mpkt};
   assign rx_ready   = !rx_full;
   assign rx_take    = rx_valid && !rx_full;
   assign rx_store   = rx_take && rx_pkt < mpkt && rx_total < rx_cap;
   assign rx_finish  = rx_end && !rx_full
                       && (!write_cont || rx_pkt < mpkt
                           || rx_total == CONT_MAX_BYTES || rx_pkt_over);
   assign rx_release = wr_phase && wr_addr == OFF_FIFO_CTRL && hwdata[CTRL_RX_REL];
   assign rx_read    = addr_take && !hwrite && haddr[7:0] == OFF_RX_DATA
                       && rx_rd < rx_total;

   always_ff @(posedge clk) begin
      if (reset) begin
         rx_full     <= 1'b0;
         rx_total    <= 9'h000;
         rx_pkt      <= 7'h00;
         rx_rd       <= 9'h000;
         rx_pkt_over <= 1'b0;
      end else begin
         if (rx_release) begin
            rx_full  <= 1'b0;
            rx_total <= 9'h000;
            rx_rd    <= 9'h000;
         end else begin
            if (rx_store) begin
               rx_total <= 9'(rx_total + 9'h001);
            end
            if (rx_read) begin
               rx_rd <= 9'(rx_rd + 9'h001);
            end
         end
         if (rx_finish) begin
            rx_full <= 1'b1;
         end
         if (rx_end) begin
            rx_pkt      <= 7'h00;
            rx_pkt_over <= 1'b0;
         end else if (rx_store) begin
            rx_pkt <= 7'(rx_pkt + 7'h01);
         end else if (rx_take) begin
            rx_pkt_over <= 1'b1;
         end
      end
   end

   // Sticky status; a new event beats a same-cycle clear
   assign stat_write = wr_phase && wr_addr == OFF_STATUS;

   always_ff @(posedge clk) begin
      if (reset) begin
         tx_done <= 1'b0;
         rx_done <= 1'b0;
         rx_over <= 1'b0;
      end else begin
         tx_done <= tx_complete || (tx_done && !(stat_write && hwdata[STAT_TX_DONE]));
         rx_done <= rx_finish || (rx_done && !(stat_write && hwdata[STAT_RX_DONE]));
         rx_over <= (rx_take && !rx_store)
                    || (rx_over && !(stat_write && hwdata[STAT_RX_OVER]));
      end
   end

   ep0_fifo_ram u_ram (
      .clk    (clk),
      .we_a   (fill_take),
      .idx_a  (buf_index(rd_blk, tx_fill)),
      .wd_a   (hwdata[7:0]),
      .we_b   (rx_store),
      .idx_b  (buf_index(wr_blk, rx_total)),
      .wd_b   (rx_data),
      .idx_r0 (buf_index(rd_blk, 9'(tx_sent + {2'h0, pkt_cnt}))),
      .rd_r0  (ram_tx_byte),
      .idx_r1 (buf_index(wr_blk, rx_rd)),
      .rd_r1  (ram_rx_byte)
   );

endmodule // ep0_ctrl_buffer
`default_nettype wire

// >>> test/ep0_ctrl_buffer_props.sv
// Port-level checker for the endpoint-zero buffering block.
// Sees only the top-level ports; attached by the bind below.
`timescale 1ns/1ps
`default_nettype none
module ep0_ctrl_buffer_props
   import ep0_buf_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        tx_start,
   input wire logic        tx_ready,
   input wire logic        tx_valid,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_last,
   input wire logic        tx_zero_length,
   input wire logic        tx_nak,
   input wire logic        rx_valid,
   input wire logic [7:0]  rx_data,
   input wire logic        rx_end,
   input wire logic        rx_ready
);
   logic bus_rd;
   logic tx_take;
   logic rel_bit;
   assign bus_rd  = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
   assign tx_take = tx_valid && tx_ready;
   assign rel_bit = hwdata[CTRL_RX_REL];
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
      else $error("bus answer not zero-wait OKAY");
   a_rdata_hold: assert property ($changed(hrdata) |-> $past(bus_rd) || $past(reset))
      else $error("read data moved without a read");
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("offered byte dropped or changed");
   a_tx_reload: assert property (tx_take |=> !tx_valid)
      else $error("no reload gap after accepted byte");
   a_tx_launch: assert property ($rose(tx_valid)
      |-> $past(tx_start, 2) || $past(tx_take, 2))
      else $error("byte offered without cause");
   a_nak_cause: assert property (tx_nak |-> tx_start && !tx_valid)
      else $error("refusal without token");
   a_zlp_pulse: assert property (tx_zero_length |=> !tx_zero_length)
      else $error("zero-length request longer than one cycle");
   a_rx_finish: assert property ($fell(rx_ready) |-> $past(rx_end))
      else $error("receive closed without packet end");
   a_rx_release: assert property ($rose(rx_ready)
      |-> $past(rel_bit) || $past(reset))
      else $error("receive buffer reopened without release");
   c_tx_last: cover property (tx_take && tx_last);
   c_rx_done: cover property ($fell(rx_ready));
   c_tx_refused: cover property (tx_nak);
   c_tx_zero: cover property (tx_zero_length);
endmodule // ep0_ctrl_buffer_props
bind ep0_ctrl_buffer ep0_ctrl_buffer_props i_props (.clk(clk), .reset(reset), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .tx_start(tx_start), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
   .tx_last(tx_last), .tx_zero_length(tx_zero_length), .tx_nak(tx_nak),
   .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .rx_ready(rx_ready));
`default_nettype wire

// >>> test/ep0_host_model.sv
// Behavioural USB host on the packet link of endpoint zero.
// Driven by bench tasks; changes its outputs just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module ep0_host_model (
   input  wire logic       clk,
   output logic            tx_start,
   output logic            tx_ready,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last,
   input  wire logic       tx_zero_length,
   input  wire logic       tx_nak,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            rx_end,
   input  wire logic       rx_ready
);
   logic [7:0] got[$];
   int         pkts = 0;
   int         naks = 0;
   int         zlps = 0;
   logic       stall = 1'b0;
   initial begin
      tx_start = 1'b0;
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      rx_end   = 1'b0;
   end
   // Slow host is ready only on every other cycle
   always @(posedge clk) begin
      tx_ready <= stall ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
         got.push_back(tx_data);
         pkts = pkts + int'(tx_last);
      end
      naks = naks + int'(tx_nak);
      zlps = zlps + int'(tx_zero_length);
   end
   task automatic in_token(input logic slow, output logic done);
      int p0;
      int n0;
      int z0;
      p0 = pkts;
      n0 = naks;
      z0 = zlps;
      stall = slow;
      done = 1'b0;
      @(posedge clk);
      tx_start <= 1'b1;
      @(posedge clk);
      tx_start <= 1'b0;
      for (int i = 0; i < 400 && !done; i++) begin
         @(posedge clk);
         done = pkts != p0 || naks != n0 || zlps != z0;
      end
      repeat (2) @(posedge clk);
   endtask
   task automatic out_packet(input int n, input logic [7:0] base);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         rx_valid <= 1'b1;
         rx_data  <= base + 8'(i);
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      // Released line must not keep showing the last byte
      rx_data  <= ~rx_data;
      rx_end   <= 1'b1;
      @(posedge clk);
      rx_end   <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask
endmodule // ep0_host_model
`default_nettype wire

// >>> test/test_ep0_ctrl_buffer.sv
// Self-checking bench for the endpoint-zero buffering block.
// Bench is the only AHB-Lite master; the host model plays the USB link.
`timescale 1ns/1ps
`default_nettype none
module test_ep0_ctrl_buffer import ep0_buf_pkg::*;;
   logic        clk, reset, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        tx_start, tx_ready, tx_valid, tx_last, tx_zero_length, tx_nak;
   logic        rx_valid, rx_end, rx_ready;
   logic [7:0]  tx_data, rx_data;
   int          num_errors = 0;
   int          checks_done = 0;
   assign hready = hreadyout;
   ep0_ctrl_buffer i_dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_start(tx_start),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
      .tx_zero_length(tx_zero_length), .tx_nak(tx_nak), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_end(rx_end), .rx_ready(rx_ready));
   ep0_host_model i_host (.clk(clk), .tx_start(tx_start), .tx_ready(tx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
      .tx_zero_length(tx_zero_length), .tx_nak(tx_nak), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_end(rx_end), .rx_ready(rx_ready));
   task automatic results();
      $display("comparisons %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
         num_errors++;
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
      q = hrdata;
      if (n >= 100) begin num_errors++; results(); end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(a, 1'b0, 32'h00000000, q);
      check(q, exp);
   endtask
   task automatic fill(input int n, input logic [7:0] base);
      for (int i = 0; i < n; i++) wr(OFF_TX_DATA, {24'h000000, base + 8'(i)});
   endtask
   task automatic drain(input int n, input logic [7:0] base);
      for (int i = 0; i < n; i++) rd(OFF_RX_DATA, {24'h000000, base + 8'(i)});
   endtask
   task automatic tok(input logic slow);
      logic ok;
      i_host.in_token(slow, ok);
      if (!ok) begin num_errors++; results(); end
   endtask
   task automatic chk_got(input int n, input logic [7:0] base);
      check(32'(i_host.got.size()), 32'(n));
      for (int i = 0; i < n; i++) check({24'h000000, i_host.got[i]}, {24'h000000, base + 8'(i)});
      i_host.got.delete();
   endtask
   task automatic t_regs();
      rd(OFF_CFG, 32'h00000000);
      rd(OFF_MPKT, 32'h00000008);
      wr(OFF_CFG, 32'h0000FFFF);
      rd(OFF_CFG, 32'h0000BFBF);
      wr(OFF_TX_LEN, 32'h000001FF);
      rd(OFF_TX_LEN, 32'h00000100);
      rd(8'h3C, 32'h00000000);
      wr(OFF_CFG, 32'h00000000);
      tok(1'b0);
      check(32'(i_host.naks), 32'h1);
      $display("test registers done");
   endtask
   task automatic t_single();
      wr(OFF_MPKT, 32'h00000008);
      wr(OFF_CFG, 32'h00002F00);
      fill(8, 8'hA0);
      rd(OFF_FIFO_CTRL, 32'h00080001);
      wr(OFF_TX_DATA, 32'h00000055);
      tok(1'b1);
      chk_got(8, 8'hA0);
      rd(OFF_STATUS, 32'h00000001);
      wr(OFF_STATUS, 32'h00000001);
      rd(OFF_FIFO_CTRL, 32'h00000000);
      fill(3, 8'h10);
      wr(OFF_FIFO_CTRL, 32'h00000001);
      rd(OFF_FIFO_CTRL, 32'h00030001);
      tok(1'b0);
      chk_got(3, 8'h10);
      wr(OFF_STATUS, 32'h00000001);
      // Valid with an empty buffer releases a zero-length packet
      wr(OFF_FIFO_CTRL, 32'h00000001);
      tok(1'b0);
      check(32'(i_host.zlps), 32'h1);
      chk_got(0, 8'h00);
      rd(OFF_STATUS, 32'h00000001);
      wr(OFF_STATUS, 32'h00000001);
      $display("test single transmit done");
   endtask
   task automatic t_cont_tx();
      wr(OFF_CFG, 32'h00008200);
      wr(OFF_TX_LEN, 32'h00000048);
      fill(72, 8'h40);
      rd(OFF_FIFO_CTRL, 32'h00480001);
      for (int k = 0; k < 8; k++) tok(k[0]);
      rd(OFF_STATUS, 32'h00000000);
      tok(1'b0);
      chk_got(72, 8'h40);
      rd(OFF_STATUS, 32'h00000001);
      wr(OFF_STATUS, 32'h00000001);
      $display("test continuous transmit done");
   endtask
   task automatic t_rx_unit();
      wr(OFF_CFG, 32'h00000005);
      i_host.out_packet(8, 8'h30);
      check({31'h0, rx_ready}, 32'h0);
      rd(OFF_STATUS, 32'h00080002);
      drain(8, 8'h30);
      wr(OFF_FIFO_CTRL, 32'h00000004);
      wr(OFF_STATUS, 32'h00000002);
      i_host.out_packet(3, 8'h70);
      rd(OFF_STATUS, 32'h00030002);
      drain(3, 8'h70);
      wr(OFF_FIFO_CTRL, 32'h00000004);
      wr(OFF_STATUS, 32'h00000002);
      // Oversized packet: ninth byte dropped, overflow flagged
      i_host.out_packet(9, 8'h50);
      rd(OFF_STATUS, 32'h00080006);
      drain(8, 8'h50);
      wr(OFF_FIFO_CTRL, 32'h00000004);
      wr(OFF_STATUS, 32'h00000006);
      check({31'h0, rx_ready}, 32'h1);
      $display("test unit receive done");
   endtask
   task automatic t_rx_cont();
      wr(OFF_CFG, 32'h00000084);
      i_host.out_packet(8, 8'h00);
      i_host.out_packet(8, 8'h08);
      check({31'h0, rx_ready}, 32'h1);
      i_host.out_packet(3, 8'h10);
      rd(OFF_STATUS, 32'h00130002);
      drain(19, 8'h00);
      wr(OFF_FIFO_CTRL, 32'h00000004);
      wr(OFF_STATUS, 32'h00000002);
      for (int k = 0; k < 32; k++) i_host.out_packet(8, 8'(k * 8));
      check({31'h0, rx_ready}, 32'h0);
      rd(OFF_STATUS, 32'h01000002);
      drain(256, 8'h00);
      wr(OFF_FIFO_CTRL, 32'h00000004);
      $display("test continuous receive done");
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      reset  = 1'b1;
      hsel   = 1'b0;
      haddr  = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h00000000;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_single();
      t_cont_tx();
      t_rx_unit();
      t_rx_cont();
      results();
   end
endmodule // test_ep0_ctrl_buffer
`default_nettype wire
